// ===== pkg/emt_map.svh
// Purpose: addresses, field positions, reset values and cycle counts
// Assumes: included by bare name
// Notes:   definitions only
`ifndef EMT_MAP_SVH
`define EMT_MAP_SVH

// timing register location on the special-function bus
`define EMT_TIMING_ADDR     8'hAA
`define EMT_TIMING_PAGE     8'h0F
`define EMT_TIMING_RESET    8'hFF

// timing register fields
`define EMT_SETUP_MSB       7
`define EMT_SETUP_LSB       6
`define EMT_STROBE_MSB      5
`define EMT_STROBE_LSB      2
`define EMT_HOLD_MSB        1
`define EMT_HOLD_LSB        0

// interface configuration fields
`define EMT_CFG_NONMUX_BIT  4
`define EMT_CFG_MODE_MSB    3
`define EMT_CFG_MODE_LSB    2
`define EMT_CFG_MODE_BANK   2'h2
`define EMT_CFG_ALE_MSB     1
`define EMT_CFG_ALE_LSB     0

// fixed overhead: one start cycle plus three closing cycles
`define EMT_OVERHEAD_CYC    4'h4
`define EMT_CLOSE_CNT       4'h2

`endif

// ===== pkg/emt_pkg.sv
// Purpose: types shared by the external memory strobe timing block
// Assumes: nothing
// Notes:   emt_tim_s follows the timing register bit layout
package emt_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START,
    ST_ALEH,
    ST_ALEL,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_CLOSE
  } emt_state_e;

  typedef struct packed {
    logic [1:0] setup;
    logic [3:0] strobe;
    logic [1:0] hold;
  } emt_tim_s;

  typedef struct packed {
    logic        write;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emt_cmd_s;

  typedef struct packed {
    logic       nonmux;
    logic       bank;
    logic [1:0] ale;
  } emt_mode_s;

endpackage

// ===== design/emt_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module emt_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1_reg <= '0;
      dout       <= '0;
    end else begin
      stage1_reg <= din;
      dout       <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

// ===== design/emt_timing_reg.sv
// Purpose: timing register on the special-function bus
// Assumes: bus signals on the system clock
// Notes:   one-cycle read latency
`include "emt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module emt_timing_reg (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // special-function bus
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrPage,
  input  wire logic       sfrWe,
  input  wire logic       sfrRe,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // register value
  output logic      [7:0] timReg
);

  logic hit;

  assign hit = (sfrAddr == `EMT_TIMING_ADDR) && (sfrPage == `EMT_TIMING_PAGE);

  // R4: register write and reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timReg <= `EMT_TIMING_RESET;
    end else if (sfrWe && hit) begin
      timReg <= sfrWdata;
    end
  end

  // R4: register readback
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfrRdata <= 8'h00;
    end else if (sfrRe) begin
      sfrRdata <= hit ? timReg : 8'h00;
    end
  end

endmodule

`default_nettype wire

// ===== design/emt_strobe_ctrl.sv
// What this block does
// R1: setup field bits 7:6 inserts zero to three cycles before strobe.
// R2: strobe field bits 5:2 gives strobe width of value plus one.
// R3: hold field bits 1:0 keeps address zero to three cycles after strobe.
// R4: timing register at 0xAA page 0x0F, read/write, resets to all ones.
// R5: codes 101,110,111 non-multiplexed; wide moves use separate pins, no ALE.
// R6: codes 101 and 111 run narrow moves without bank select.
// R7: code 110 runs narrow moves with bank select.
// R8: codes 001,010,011 multiplexed; address low shares data pins via ALE.
// R9: codes 001 and 011 run narrow moves without bank select.
// R10: code 010 runs narrow moves with bank select.
// R11: move lasts setup plus strobe plus hold plus four cycles; multiplexed moves also add both ALE widths.
// R12: multiplexed ALE high and low widths each equal low bits plus one.
// R13: bank select drives upper byte from bank, lower from pointer.
// R14: no bank select leaves upper address lines undriven on narrow moves.
// R15: order is address setup, strobe, address hold, then release.
// R16: memory gives read data before strobe ends, takes write on strobe.
//
// Purpose: timing generator for off-chip external moves
// Assumes: one move at a time, request only while idle
// Notes:   pin outputs registered; data pins synchronised on input
`include "emt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module emt_strobe_ctrl (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // special-function bus
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrPage,
  input  wire logic       sfrWe,
  input  wire logic       sfrRe,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // interface configuration and bank
  input  wire logic [4:0] extCfg,
  input  wire logic [7:0] upperAddrBank,
  // external move request
  input  wire logic       movReq,
  input  wire logic       movWrite,
  input  wire logic       movWide,
  input  wire logic [15:0] movAddr,
  input  wire logic [7:0] movWdata,
  output logic            movBusy,
  output logic            movDone,
  output logic      [7:0] movRdata,
  // memory pins
  output logic      [7:0] addrHiOut,
  output logic            addrHiOe,
  output logic      [7:0] addrLoOut,
  output logic            addrLoOe,
  output logic      [7:0] adOut,
  output logic            adOe,
  input  wire logic [7:0] adIn,
  output logic            ale,
  output logic            rdB,
  output logic            wrB
);

  // ****************************************************************
  // register and synchroniser
  // ****************************************************************
  logic [7:0] timReg;
  logic [7:0] adSync;

  emt_timing_reg u_reg (
    .clk      (clk),
    .rst_b    (rst_b),
    .sfrAddr  (sfrAddr),
    .sfrPage  (sfrPage),
    .sfrWe    (sfrWe),
    .sfrRe    (sfrRe),
    .sfrWdata (sfrWdata),
    .sfrRdata (sfrRdata),
    .timReg   (timReg)
  );

  emt_sync #(.W(8)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (adIn),
    .dout  (adSync)
  );

  // ****************************************************************
  // request capture
  // ****************************************************************
  emt_pkg::emt_state_e state_reg;
  emt_pkg::emt_state_e state_next;
  emt_pkg::emt_tim_s   tim_reg;
  emt_pkg::emt_cmd_s   cmd_reg;
  emt_pkg::emt_mode_s  mode_reg;
  logic [3:0]          cnt_reg;
  logic [3:0]          cnt_next;
  logic                accept;

  assign accept = movReq && (state_reg == emt_pkg::ST_IDLE);

  // R5: mode decode from configuration
  // R8: mode decode from configuration
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tim_reg  <= '0;
      cmd_reg  <= '0;
      mode_reg <= '0;
    end else if (accept) begin
      tim_reg         <= emt_pkg::emt_tim_s'(timReg);
      cmd_reg.write   <= movWrite;
      cmd_reg.wide    <= movWide;
      cmd_reg.addr    <= movAddr;
      cmd_reg.wdata   <= movWdata;
      mode_reg.nonmux <= extCfg[`EMT_CFG_NONMUX_BIT];
      // R6: no bank for 101 and 111
      // R7: bank timing for 110
      // R9: no bank for 001 and 011
      // R10: bank timing for 010
      mode_reg.bank   <= extCfg[`EMT_CFG_MODE_MSB:`EMT_CFG_MODE_LSB]
                         == `EMT_CFG_MODE_BANK;
      mode_reg.ale    <= extCfg[`EMT_CFG_ALE_MSB:`EMT_CFG_ALE_LSB];
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // R15: setup, strobe, hold order
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      emt_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = emt_pkg::ST_START;
        end
      end
      emt_pkg::ST_START: begin
        if (!mode_reg.nonmux) begin
          // R12: ALE high width
          state_next = emt_pkg::ST_ALEH;
          cnt_next   = {2'b00, mode_reg.ale};
        end else if (tim_reg.setup != 2'b00) begin
          state_next = emt_pkg::ST_SETUP;
          cnt_next   = {2'b00, tim_reg.setup - 2'b01};
        end else begin
          state_next = emt_pkg::ST_STROBE;
          cnt_next   = tim_reg.strobe;
        end
      end
      emt_pkg::ST_ALEH: begin
        if (cnt_reg == 4'h0) begin
          // R12: ALE low width
          state_next = emt_pkg::ST_ALEL;
          cnt_next   = {2'b00, mode_reg.ale};
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      emt_pkg::ST_ALEL: begin
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else if (tim_reg.setup != 2'b00) begin
          state_next = emt_pkg::ST_SETUP;
          cnt_next   = {2'b00, tim_reg.setup - 2'b01};
        end else begin
          state_next = emt_pkg::ST_STROBE;
          cnt_next   = tim_reg.strobe;
        end
      end
      emt_pkg::ST_SETUP: begin
        // R1: setup interval
        if (cnt_reg == 4'h0) begin
          state_next = emt_pkg::ST_STROBE;
          cnt_next   = tim_reg.strobe;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      emt_pkg::ST_STROBE: begin
        // R2: strobe width
        if (cnt_reg != 4'h0) begin
          cnt_next = cnt_reg - 4'h1;
        end else if (tim_reg.hold != 2'b00) begin
          state_next = emt_pkg::ST_HOLD;
          cnt_next   = {2'b00, tim_reg.hold - 2'b01};
        end else begin
          state_next = emt_pkg::ST_CLOSE;
          cnt_next   = `EMT_CLOSE_CNT;
        end
      end
      emt_pkg::ST_HOLD: begin
        // R3: hold interval
        if (cnt_reg == 4'h0) begin
          state_next = emt_pkg::ST_CLOSE;
          cnt_next   = `EMT_CLOSE_CNT;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      emt_pkg::ST_CLOSE: begin
        // R11: fixed closing overhead
        if (cnt_reg == 4'h0) begin
          state_next = emt_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        state_next = emt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= emt_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  logic addrPhase;
  logic dataPhase;
  logic hiDrive;

  assign addrPhase = state_next inside {emt_pkg::ST_ALEH, emt_pkg::ST_ALEL,
                     emt_pkg::ST_SETUP, emt_pkg::ST_STROBE, emt_pkg::ST_HOLD};
  assign dataPhase = state_next inside {emt_pkg::ST_SETUP,
                     emt_pkg::ST_STROBE, emt_pkg::ST_HOLD};
  assign hiDrive   = cmd_reg.wide || mode_reg.bank;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addrHiOut <= 8'h00;
      addrHiOe  <= 1'b0;
    end else begin
      // R13: bank byte on upper lines
      // R14: upper lines left to port latches
      addrHiOe  <= addrPhase && hiDrive;
      addrHiOut <= cmd_reg.wide ? cmd_reg.addr[15:8] : upperAddrBank;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addrLoOut <= 8'h00;
      addrLoOe  <= 1'b0;
      adOut     <= 8'h00;
      adOe      <= 1'b0;
      ale       <= 1'b0;
    end else begin
      // R5: separate low address pins
      addrLoOe  <= addrPhase && mode_reg.nonmux;
      addrLoOut <= cmd_reg.addr[7:0];
      // R8: address then data on shared pins
      if (!mode_reg.nonmux && addrPhase && !dataPhase) begin
        adOut <= cmd_reg.addr[7:0];
        adOe  <= 1'b1;
      end else begin
        adOut <= cmd_reg.wdata;
        adOe  <= dataPhase && cmd_reg.write;
      end
      ale <= (state_next == emt_pkg::ST_ALEH);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdB <= 1'b1;
      wrB <= 1'b1;
    end else begin
      // R2: strobe active only in strobe state
      rdB <= !((state_next == emt_pkg::ST_STROBE) && !cmd_reg.write);
      wrB <= !((state_next == emt_pkg::ST_STROBE) && cmd_reg.write);
    end
  end

  // ****************************************************************
  // read capture and status
  // ****************************************************************
  logic [1:0] capPipe_reg;

  // R16: data sampled at last strobe cycle, two stages late
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      capPipe_reg <= 2'b00;
      movRdata    <= 8'h00;
    end else begin
      capPipe_reg <= {capPipe_reg[0], !rdB && (state_next !=
                      emt_pkg::ST_STROBE)};
      if (capPipe_reg[1]) begin
        movRdata <= adSync;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      movBusy <= 1'b0;
      movDone <= 1'b0;
    end else begin
      movBusy <= state_next != emt_pkg::ST_IDLE;
      movDone <= (state_reg == emt_pkg::ST_CLOSE) && (cnt_reg == 4'h0);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [5:0] moveCnt;
  logic [4:0] strbCnt;
  logic [2:0] aleCnt;
  logic [5:0] expTotal;

  always_ff @(posedge clk) begin
    if (!rst_b || accept) begin
      moveCnt <= 6'h00;
    end else if (state_reg != emt_pkg::ST_IDLE) begin
      moveCnt <= moveCnt + 6'h01;
    end
    strbCnt <= (!rdB || !wrB) ? strbCnt + 5'h01 : 5'h00;
    aleCnt  <= ale ? aleCnt + 3'h1 : 3'h0;
  end

  assign expTotal = 6'(tim_reg.setup) + 6'(tim_reg.strobe) + 6'h01
                  + 6'(tim_reg.hold) + 6'(`EMT_OVERHEAD_CYC)
                  + (mode_reg.nonmux ? 6'h00 : 6'({mode_reg.ale, 1'b0})
                  + 6'h02);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_timing_reset: assert property (disable iff (1'b0) // R4
    $rose(rst_b) |-> timReg == `EMT_TIMING_RESET)
    else $error("timing register not all ones after reset");
  a_strobe_width: assert property ( // R2
    ($rose(rdB) || $rose(wrB)) |-> 5'(tim_reg.strobe) + 5'h01 == strbCnt)
    else $error("strobe width wrong");
  a_move_total: assert property ( // R11
    movDone |-> moveCnt == expTotal)
    else $error("move duration wrong");
  a_setup_gap: assert property ( // R1
    ($fell(rdB) || $fell(wrB)) && mode_reg.nonmux
    |-> $past(addrLoOe) == (|tim_reg.setup) && !$past(addrLoOe, 4)
    && $past(addrLoOe, 2) == tim_reg.setup[1]
    && $past(addrLoOe, 3) == (&tim_reg.setup))
    else $error("setup gap wrong");
  a_hold_tail: assert property ( // R3
    ($rose(rdB) || $rose(wrB)) && tim_reg.hold == 2'b11
    |-> (addrLoOe == mode_reg.nonmux) [*3] ##1 !addrLoOe)
    else $error("address hold wrong");
  a_ale_width: assert property ( // R12
    $fell(ale) |-> aleCnt == 3'(mode_reg.ale) + 3'h1)
    else $error("ALE width wrong");
  a_nonmux_ale: assert property ( // R5
    mode_reg.nonmux && movBusy |-> !ale)
    else $error("ALE pulsed in non-multiplexed mode");
  a_bank_upper: assert property ( // R13
    !rdB && !cmd_reg.wide && mode_reg.bank
    |-> addrHiOe && addrHiOut == $past(upperAddrBank))
    else $error("bank byte not driven");
  a_nobank_upper: assert property ( // R14
    movBusy && !cmd_reg.wide && !mode_reg.bank |-> !addrHiOe)
    else $error("upper lines driven without bank select");
  a_strobe_addr: assert property ( // R15
    (!rdB || !wrB) |-> (addrLoOe || adOe || !mode_reg.nonmux) && !ale)
    else $error("strobe outside address window");

endmodule

`default_nettype wire

// ===== sim/emt_sram_model.sv
// Purpose: external memory with address latch on the ALE and shared data pins
// Assumes: pins of emt_strobe_ctrl, one clock
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module emt_sram_model (
  // clock and mode
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [7:0] portHi,
  // memory pins
  input  wire logic [7:0] addrHiOut,
  input  wire logic       addrHiOe,
  input  wire logic [7:0] addrLoOut,
  input  wire logic       addrLoOe,
  input  wire logic [7:0] adOut,
  input  wire logic       ale,
  input  wire logic       rdB,
  input  wire logic       wrB,
  output logic      [7:0] adIn
);
  // ****
  // storage and latch
  // ****
  logic [7:0]  mem [0:65535];
  logic [7:0]  latchQ = 8'h00;
  logic [7:0]  lastReg = 8'h00;
  logic        lateReg = 1'b0;
  logic [15:0] addr;

  always @(ale or adOut) begin
    if (ale) latchQ = adOut;
  end
  assign addr = {addrHiOe ? addrHiOut : portHi,
                 addrLoOe ? addrLoOut : latchQ};

  always @(posedge clk) begin
    if (!wrB) mem[addr] <= adOut;
  end

  assign adIn = (!rdB && !(slow && !lateReg)) ? mem[addr] : ~lastReg;
  always @(posedge clk) begin
    lateReg <= !rdB;
    if (!rdB) lastReg <= adIn;
  end
endmodule

`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for emt_strobe_ctrl
// Assumes: memory model on the pins
// Notes:   pin phases counted each cycle during a move
`include "emt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ****
  // signals
  // ****
  logic        clk, rst_b, sfrWe, sfrRe, movReq, movWrite, movWide;
  logic        movBusy, movDone, addrHiOe, addrLoOe, adOe, ale, rdB, wrB;
  logic        slow;
  logic [7:0]  sfrAddr, sfrPage, sfrWdata, sfrRdata, upperAddrBank;
  logic [7:0]  movWdata, movRdata, addrHiOut, addrLoOut, adOut, adIn;
  logic [7:0]  portHi, rd, tim, rv;
  logic [4:0]  extCfg;
  logic [15:0] movAddr, ra;
  integer      err_total, n_compared, seed, k;
  int          expMem [int];
  logic [2:0]  codes [6] = '{3'b101, 3'b110, 3'b111, 3'b001, 3'b010, 3'b011};

  emt_strobe_ctrl u_dut (.clk, .rst_b, .sfrAddr, .sfrPage, .sfrWe, .sfrRe,
    .sfrWdata, .sfrRdata, .extCfg, .upperAddrBank, .movReq, .movWrite,
    .movWide, .movAddr, .movWdata, .movBusy, .movDone, .movRdata,
    .addrHiOut, .addrHiOe, .addrLoOut, .addrLoOe, .adOut, .adOe, .adIn,
    .ale, .rdB, .wrB);
  emt_sram_model u_mem (.clk, .slow, .portHi, .addrHiOut, .addrHiOe,
    .addrLoOut, .addrLoOe, .adOut, .ale, .rdB, .wrB, .adIn);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****
  // tasks
  // ****
  task automatic chk(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic sfr(input bit we, input logic [7:0] a, p, d);
    @(posedge clk);
    #1;
    sfrWe = we;
    sfrRe = !we;
    sfrAddr = a;
    sfrPage = p;
    sfrWdata = d;
    @(posedge clk);
    #1;
    sfrWe = 1'b0;
    sfrRe = 1'b0;
    @(posedge clk);
    #1;
    rd = sfrRdata;
  endtask

  task automatic move(input bit w, wd, input logic [15:0] a,
                      input logic [7:0] d);
    int n = 0, stb = 0, pre = 0, hold = 0, aleH = 0, dOe = 0;
    int s = tim[7:6], wf = tim[5:2], h = tim[1:0], al = extCfg[1:0];
    bit mux = !extCfg[4], bank = (extCfg[3:2] == 2'b10), hiOe = 0;
    logic [7:0] hiSeen = 8'h00, loSeen = 8'h00, hiExp;
    hiExp = wd ? a[15:8] : (bank ? upperAddrBank : portHi);
    @(posedge clk);
    #1;
    movReq = 1'b1;
    movWrite = w;
    movWide = wd;
    movAddr = a;
    movWdata = d;
    @(posedge clk);
    #1;
    movReq = 1'b0;
    while (movDone !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
      // request while busy must be ignored
      if (n == 2) begin
        movReq = 1'b1;
        movWdata = ~d;
        movAddr = ~a;
      end
      if (n == 3) movReq = 1'b0;
      if (movDone !== 1'b1) chk("busy", movBusy, 1);
      if (adOe === 1'b1) dOe++;
      if (ale === 1'b1) begin
        aleH++;
        loSeen = adOut;
      end
      if (rdB === 1'b0 || wrB === 1'b0) begin
        stb++;
        hiOe = addrHiOe;
        hiSeen = addrHiOut;
        if (!mux) loSeen = addrLoOut;
      end else if (stb == 0 && (mux ? (aleH > 0 && ale === 1'b0)
                                    : addrLoOe === 1'b1)) pre++;
      else if (stb > 0 && (addrLoOe === 1'b1 || addrHiOe === 1'b1)) hold++;
    end
    chk("done", movDone, 1);
    chk("idle", movBusy, 0);
    chk("ad_oe", dOe,
        (w ? s + wf + h + 1 : 0) + (mux ? 2 * al + 2 : 0));
    chk("cycles", n, s + wf + 5 + h + (mux ? 2 * (al + 1) : 0));
    chk("strobe", stb, wf + 1);
    chk("setup", pre, s + (mux ? al + 1 : 0));
    chk("hold", hold, (mux && !wd && !bank) ? 0 : h);
    chk("ale", aleH, mux ? al + 1 : 0);
    chk("hi_oe", hiOe, wd | bank);
    if (wd | bank) chk("hi", hiSeen, hiExp);
    chk("lo", loSeen, a[7:0]);
    if (w) expMem[{hiExp, a[7:0]}] = d;
    else chk("rdata", movRdata, expMem[{hiExp, a[7:0]}]);
    @(posedge clk);
    #1;
    chk("pulse", movDone, 0);
  endtask

  // ****
  // sequence
  // ****
  initial begin
    err_total = 0;
    n_compared = 0;
    seed = 32'h833a_0a84;
    rst_b = 1'b0;
    {sfrWe, sfrRe, movReq, movWrite, movWide, slow} = 6'h00;
    {sfrAddr, sfrPage, sfrWdata, upperAddrBank} = 32'h0000_0000;
    {movAddr, movWdata, portHi} = 32'h0000_0000;
    extCfg = 5'h14;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    sfr(0, `EMT_TIMING_ADDR, `EMT_TIMING_PAGE, 8'h00);
    chk("tim_rst", rd, 8'hFF);
    tim = 8'hFF;
    move(1, 1, 16'h1234, 8'hC3);
    move(0, 1, 16'h1234, 8'h00);
    sfr(1, 8'hAB, `EMT_TIMING_PAGE, 8'h00);
    sfr(0, 8'hAB, `EMT_TIMING_PAGE, 8'h00);
    chk("unmapped", rd, 8'h00);
    sfr(1, `EMT_TIMING_ADDR, 8'h0E, 8'h00);
    sfr(0, `EMT_TIMING_ADDR, `EMT_TIMING_PAGE, 8'h00);
    chk("tim_keep", rd, 8'hFF);
    for (k = 0; k < 24; k++) begin
      tim = 8'($random(seed));
      slow = k[0];
      if (k == 2) tim[5:2] = 4'h0;
      if (k == 4) tim = 8'h00;
      if (slow) tim[2] = 1'b1;
      extCfg = {codes[k % 6], 2'(k / 6)};
      upperAddrBank = 8'($random(seed));
      portHi = 8'($random(seed));
      ra = 16'($random(seed));
      rv = 8'($random(seed));
      sfr(1, `EMT_TIMING_ADDR, `EMT_TIMING_PAGE, tim);
      sfr(0, `EMT_TIMING_ADDR, `EMT_TIMING_PAGE, 8'h00);
      chk("tim", rd, tim);
      move(1, k[1], ra, rv);
      move(0, k[1], ra, 8'h00);
    end
    final_report;
  end

  // watchdog: about eight times the expected run
  initial begin
    #(20 * 10000);
    err_total++;
    final_report;
  end
endmodule

`default_nettype wire
